// ==== verilog/input_event_timestamp_logger.sv ====
// Input event time-stamp logger: config check, edge stamping, record store, reporting
// Functional notes
// - Configuration record selects channels and edge sense
// - Reject configuration inconsistent with module structure
// - Stamping enabled only after accepted configuration
// - Stamp each change, store in records 100-114
// - Active unit raises process interrupt after record is stored
// - Diagnostic answer names record holding events
// - Messages are 12 bytes, 20 per record
// - Both redundant units keep stored messages
// - No stamping in changeover; mark begin and end
// - Resynchronize time every 10 s, intervals match
// - Stamp with 1 ms resolution when synchronized
// - Log both edges; configured edge is incoming
`timescale 1ns/1ps
module input_event_timestamp_logger
  import stamp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Digital inputs and redundancy state (pins)
  input wire logic [CH_NUM-1:0] din_i,
  input wire logic changeover_i,
  input wire logic active_i,
  // Slave module structure
  input wire logic [MOD_NUM-1:0] mod_present_i,
  // Configuration record write
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_rec_i,
  input wire logic [CH_NUM-1:0] cfg_chan_mask_i,
  input wire logic cfg_rising_in_i,
  output logic cfg_ack_o,
  output logic cfg_err_o,
  output logic stamping_on_o,
  // Time frames
  input wire logic time_sync_i,
  input wire logic [63:0] time_val_i,
  output logic synced_o,
  // Interrupt and diagnosis
  output logic proc_irq_o,
  input wire logic diag_req_i,
  output logic diag_valid_o,
  output logic [7:0] diag_rec_o,
  output logic [4:0] diag_cnt_o,
  // Record read and release
  input wire logic rd_req_i,
  input wire logic rd_release_i,
  input wire logic [7:0] rd_rec_i,
  input wire logic [4:0] rd_msg_i,
  output logic rd_valid_o,
  output logic rd_err_o,
  output logic [MSG_W-1:0] rd_data_o
);
  localparam int TW = $clog2(TICK_CYC + 1);

  function automatic logic [8:0] mem_index(input logic [3:0] rec, input logic [4:0] msg);
    mem_index = 9'(rec * MSG_PER_REC + msg);
  endfunction

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p == 4'(REC_NUM - 1)) ? 4'h0 : p + 4'h1;
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [CH_NUM+1:0] pin_s1_reg;
  logic [CH_NUM+1:0] pin_s2_reg;
  logic [CH_NUM-1:0] din_d_reg;
  logic co_d_reg;
  logic [CH_NUM-1:0] din_s;
  logic co_s;
  logic act_s;

  assign din_s = pin_s2_reg[CH_NUM-1:0];
  assign co_s = pin_s2_reg[CH_NUM];
  assign act_s = pin_s2_reg[CH_NUM+1];

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      din_d_reg <= '0;
      co_d_reg <= 1'b0;
    end
    else
    begin
      pin_s1_reg <= {active_i, changeover_i, din_i};
      pin_s2_reg <= pin_s1_reg;
      din_d_reg <= din_s;
      co_d_reg <= co_s;
    end
  end

  // ------------------------------------------------------------
  // Configuration record
  // ------------------------------------------------------------
  logic [CH_NUM-1:0] chan_en_reg;
  logic rising_in_reg;
  logic stamp_on_reg;
  logic cfg_ack_reg;
  logic cfg_err_reg;
  logic cfg_ok;

  always_comb
  begin
    cfg_ok = (cfg_rec_i == REC_CFG) && (|cfg_chan_mask_i);
    for (int m = 0; m < MOD_NUM; m++)
    begin
      if ((|cfg_chan_mask_i[m*CH_PER_MOD +: CH_PER_MOD]) && !mod_present_i[m])
      begin
        cfg_ok = 1'b0;
      end
    end
  end

  // A rejected record leaves the previous setup running untouched
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      chan_en_reg <= MASK_RST;
      rising_in_reg <= 1'b1;
      stamp_on_reg <= 1'b0;
      cfg_ack_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
    end
    else
    begin
      cfg_ack_reg <= cfg_wr_i && cfg_ok;
      cfg_err_reg <= cfg_wr_i && !cfg_ok;
      if (cfg_wr_i && cfg_ok)
      begin
        chan_en_reg <= cfg_chan_mask_i;
        rising_in_reg <= cfg_rising_in_i;
        stamp_on_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Time base and synchronisation
  // ------------------------------------------------------------
  logic [TW-1:0] tick_cnt_reg;
  logic [63:0] time_reg;
  logic [15:0] since_reg;
  logic synced_reg;
  logic ms_tick;

  assign ms_tick = tick_cnt_reg == TW'(TICK_CYC - 1);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick_cnt_reg <= '0;
      time_reg <= TIME_RST;
      since_reg <= '0;
      synced_reg <= 1'b0;
    end
    else if (time_sync_i)
    begin
      tick_cnt_reg <= '0;
      time_reg <= time_val_i;
      since_reg <= '0;
      synced_reg <= (since_reg >= GAP_MIN) && (since_reg <= GAP_MAX);
    end
    else
    begin
      tick_cnt_reg <= ms_tick ? '0 : tick_cnt_reg + 1'b1;
      if (ms_tick)
      begin
        time_reg <= time_reg + 64'h1;
        if (since_reg != 16'hffff)
        begin
          since_reg <= since_reg + 16'h1;
        end
        if (since_reg == GAP_MAX)
        begin
          synced_reg <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Edge capture
  // ------------------------------------------------------------
  logic [CH_NUM-1:0] pend_reg;
  logic [CH_NUM-1:0] dir_in_reg;
  logic [63:0] ts_reg [CH_NUM];
  logic co_beg_reg;
  logic co_end_reg;
  logic [CH_NUM-1:0] pend_set;
  logic [CH_NUM-1:0] pend_clr;
  logic co_beg_clr;
  logic co_end_clr;
  logic co_rise;
  logic co_fall;

  // Changeover suppresses new stamps; both edges count otherwise
  assign pend_set = (din_s ^ din_d_reg) & chan_en_reg & {CH_NUM{stamp_on_reg && !co_s}};
  assign co_rise = co_s && !co_d_reg && stamp_on_reg;
  assign co_fall = !co_s && co_d_reg && stamp_on_reg;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pend_reg <= '0;
      dir_in_reg <= '0;
      co_beg_reg <= 1'b0;
      co_end_reg <= 1'b0;
    end
    else
    begin
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      co_beg_reg <= (co_beg_reg && !co_beg_clr) || co_rise;
      co_end_reg <= (co_end_reg && !co_end_clr) || co_fall;
      for (int c = 0; c < CH_NUM; c++)
      begin
        if (pend_set[c])
        begin
          dir_in_reg[c] <= din_s[c] == rising_in_reg;
        end
      end
    end
  end

  // Latest edge wins when a channel toggles again before its message leaves
  always_ff @(posedge clk_i)
  begin
    for (int c = 0; c < CH_NUM; c++)
    begin
      if (pend_set[c])
      begin
        ts_reg[c] <= time_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Message assembly into the buffer
  // ------------------------------------------------------------
  logic src_valid;
  logic src_ready;
  logic [MSG_W-1:0] src_msg;
  logic buf_valid;
  logic buf_ready;
  logic [MSG_W-1:0] buf_msg;

  always_comb
  begin
    src_valid = 1'b0;
    src_msg = '0;
    pend_clr = '0;
    co_beg_clr = 1'b0;
    co_end_clr = 1'b0;
    src_msg[QUAL_POS +: 8] = {7'h0, synced_reg};
    src_msg[TIME_POS +: 64] = time_reg;
    if (co_beg_reg || co_end_reg)
    begin
      src_valid = 1'b1;
      src_msg[TYPE_POS +: 8] = MSG_CHANGEOVER;
      src_msg[DIR_POS +: 8] = co_beg_reg ? DIR_IN : DIR_OUT;
      co_beg_clr = co_beg_reg && src_ready;
      co_end_clr = !co_beg_reg && src_ready;
    end
    else
    begin
      for (int c = CH_NUM - 1; c >= 0; c--)
      begin
        if (pend_reg[c])
        begin
          src_valid = 1'b1;
          pend_clr = '0;
          pend_clr[c] = src_ready;
          src_msg[TYPE_POS +: 8] = MSG_SIGNAL;
          src_msg[CHAN_POS +: 8] = 8'(c);
          src_msg[DIR_POS +: 8] = dir_in_reg[c] ? DIR_IN : DIR_OUT;
          src_msg[TIME_POS +: 64] = ts_reg[c];
        end
      end
    end
  end

  msg_buffer #(
    .WIDTH(MSG_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .s_valid_i(src_valid),
    .s_ready_o(src_ready),
    .s_data_i(src_msg),
    .m_valid_o(buf_valid),
    .m_ready_i(buf_ready),
    .m_data_o(buf_msg)
  );

  // ------------------------------------------------------------
  // Record store
  // ------------------------------------------------------------
  wr_state_t wr_state_reg;
  logic [3:0] wr_ptr_reg;
  logic [3:0] rd_ptr_reg;
  logic [4:0] wr_cnt_reg;
  logic [REC_NUM-1:0] closed_reg;
  logic [4:0] rec_cnt_reg [REC_NUM];
  logic [MSG_W-1:0] msg_mem [MEM_DEPTH];
  logic store;
  logic release_ok;

  // Stalling on an unread record pushes back into the buffer and the pending bits
  assign buf_ready = (wr_state_reg == WR_FILL) || (wr_state_reg == WR_IDLE && !closed_reg[wr_ptr_reg]);
  assign store = buf_valid && buf_ready;
  assign release_ok = rd_release_i && closed_reg[rd_ptr_reg] && (rd_rec_i == REC_FIRST + 8'(rd_ptr_reg));

  always_ff @(posedge clk_i)
  begin
    if (store)
    begin
      msg_mem[mem_index(wr_ptr_reg, wr_cnt_reg)] <= buf_msg;
    end
  end

  // Both redundant units keep filling records whatever their role
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_state_reg <= WR_IDLE;
      wr_ptr_reg <= '0;
      wr_cnt_reg <= '0;
    end
    else
    begin
      case (wr_state_reg)
        WR_IDLE:
        begin
          if (store)
          begin
            wr_cnt_reg <= 5'h1;
            wr_state_reg <= WR_FILL;
          end
        end
        WR_FILL:
        begin
          if (store)
          begin
            wr_cnt_reg <= wr_cnt_reg + 5'h1;
            if (wr_cnt_reg == 5'(MSG_PER_REC - 1))
            begin
              wr_state_reg <= WR_CLOSE;
            end
          end
          else if (!buf_valid)
          begin
            wr_state_reg <= WR_CLOSE;
          end
        end
        WR_CLOSE:
        begin
          wr_ptr_reg <= ptr_inc(wr_ptr_reg);
          wr_cnt_reg <= '0;
          wr_state_reg <= WR_IDLE;
        end
        default:
        begin
          wr_state_reg <= WR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      closed_reg <= '0;
      rd_ptr_reg <= '0;
      for (int r = 0; r < REC_NUM; r++)
      begin
        rec_cnt_reg[r] <= '0;
      end
    end
    else
    begin
      if (release_ok)
      begin
        closed_reg[rd_ptr_reg] <= 1'b0;
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      end
      if (wr_state_reg == WR_CLOSE)
      begin
        closed_reg[wr_ptr_reg] <= 1'b1;
        rec_cnt_reg[wr_ptr_reg] <= wr_cnt_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt, diagnosis and record read
  // ------------------------------------------------------------
  logic irq_reg;
  logic diag_valid_reg;
  logic [7:0] diag_rec_reg;
  logic [4:0] diag_cnt_reg;
  logic rd_valid_reg;
  logic rd_err_reg;
  logic [MSG_W-1:0] rd_data_reg;
  logic [7:0] rd_off;
  logic rd_ok;

  assign rd_off = rd_rec_i - REC_FIRST;
  assign rd_ok = rd_rec_i >= REC_FIRST && rd_rec_i <= REC_LAST && closed_reg[rd_off[3:0]]
    && rd_msg_i < rec_cnt_reg[rd_off[3:0]];

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      irq_reg <= 1'b0;
      diag_valid_reg <= 1'b0;
      diag_rec_reg <= REC_NONE;
      diag_cnt_reg <= '0;
      rd_valid_reg <= 1'b0;
      rd_err_reg <= 1'b0;
      rd_data_reg <= '0;
    end
    else
    begin
      irq_reg <= (wr_state_reg == WR_CLOSE) && act_s;
      diag_valid_reg <= diag_req_i && act_s;
      if (diag_req_i && act_s)
      begin
        diag_rec_reg <= closed_reg[rd_ptr_reg] ? REC_FIRST + 8'(rd_ptr_reg) : REC_NONE;
        diag_cnt_reg <= closed_reg[rd_ptr_reg] ? rec_cnt_reg[rd_ptr_reg] : 5'h0;
      end
      rd_valid_reg <= rd_req_i && rd_ok;
      rd_err_reg <= rd_req_i && !rd_ok;
      if (rd_req_i && rd_ok)
      begin
        rd_data_reg <= msg_mem[mem_index(rd_off[3:0], rd_msg_i)];
      end
    end
  end

  assign cfg_ack_o = cfg_ack_reg;
  assign cfg_err_o = cfg_err_reg;
  assign stamping_on_o = stamp_on_reg;
  assign synced_o = synced_reg;
  assign proc_irq_o = irq_reg;
  assign diag_valid_o = diag_valid_reg;
  assign diag_rec_o = diag_rec_reg;
  assign diag_cnt_o = diag_cnt_reg;
  assign rd_valid_o = rd_valid_reg;
  assign rd_err_o = rd_err_reg;
  assign rd_data_o = rd_data_reg;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence diag_ask_s;
    diag_req_i && act_s;
  endsequence
  sequence diag_ans_s;
    diag_valid_o ##1 (!diag_valid_o || $past(diag_req_i && act_s));
  endsequence

  cfg_reject_a: assert property (cfg_wr_i && !cfg_ok |=> cfg_err_o && !cfg_ack_o)
    else $error("bad configuration record not rejected");
  stamp_enable_a: assert property (cfg_wr_i && cfg_ok |=> stamping_on_o && cfg_ack_o)
    else $error("stamping not enabled after good configuration");
  no_log_off_a: assert property (!stamp_on_reg |-> pend_reg == '0 && !buf_valid)
    else $error("event logged before configuration");
  rec_range_a: assert property (diag_valid_o && diag_rec_o != REC_NONE |->
    diag_rec_o >= REC_FIRST && diag_rec_o <= REC_LAST && diag_cnt_o != 5'h0)
    else $error("reported record out of range");
  irq_close_a: assert property (wr_state_reg == WR_CLOSE && act_s |=> proc_irq_o ##1 !proc_irq_o)
    else $error("no interrupt after record close");
  diag_answer_a: assert property (diag_ask_s |=> diag_ans_s)
    else $error("diagnosis request not answered");
  rec_limit_a: assert property (wr_state_reg == WR_FILL && wr_cnt_reg == 5'(MSG_PER_REC) |-> !buf_ready)
    else $error("record exceeds message limit");
  co_gap_a: assert property (co_s |=> (pend_reg & ~$past(pend_reg)) == '0)
    else $error("input stamped during changeover");
  co_mark_a: assert property ($rose(co_s) && stamp_on_reg |=> co_beg_reg)
    else $error("changeover begin not marked");
  sync_drop_a: assert property (ms_tick && !time_sync_i && since_reg == GAP_MAX |=> !synced_o)
    else $error("sync kept after missing time frame");
  no_overwrite_a: assert property (store && wr_state_reg == WR_IDLE |-> !closed_reg[wr_ptr_reg])
    else $error("unread record overwritten");
endmodule // input_event_timestamp_logger

// ==== verilog/stamp_pkg.sv ====
// Constants and types shared by the event time-stamp logger
package stamp_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int CH_NUM = 32;
  localparam int MOD_NUM = 4;
  localparam int CH_PER_MOD = 8;
  localparam int MSG_BYTES = 12;
  localparam int MSG_W = MSG_BYTES * 8;
  localparam int MSG_PER_REC = 20;
  localparam int REC_NUM = 15;
  localparam int MEM_DEPTH = REC_NUM * MSG_PER_REC;
  localparam int BUF_DEPTH = 2;
  // ------------------------------------------------------------
  // Record numbers
  // ------------------------------------------------------------
  localparam logic [7:0] REC_CFG = 8'hf0;
  localparam logic [7:0] REC_FIRST = 8'h64;
  localparam logic [7:0] REC_LAST = 8'h72;
  localparam logic [7:0] REC_NONE = 8'h00;
  // ------------------------------------------------------------
  // Message fields
  // ------------------------------------------------------------
  localparam logic [7:0] MSG_SIGNAL = 8'h01;
  localparam logic [7:0] MSG_CHANGEOVER = 8'h02;
  localparam logic [7:0] DIR_IN = 8'h01;
  localparam logic [7:0] DIR_OUT = 8'h00;
  localparam int TYPE_POS = 0;
  localparam int CHAN_POS = 8;
  localparam int DIR_POS = 16;
  localparam int QUAL_POS = 24;
  localparam int TIME_POS = 32;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int SYNC_INTERVAL_MS = 10000;
  localparam int SYNC_TOL_MS = 100;
  localparam logic [15:0] GAP_MIN = 16'(SYNC_INTERVAL_MS - SYNC_TOL_MS);
  localparam logic [15:0] GAP_MAX = 16'(SYNC_INTERVAL_MS + SYNC_TOL_MS);
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [63:0] TIME_RST = 64'h0;
  localparam logic [CH_NUM-1:0] MASK_RST = 32'h0;
  // ------------------------------------------------------------
  // Record writer states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_FILL = 2'b01,
    WR_CLOSE = 2'b10
  } wr_state_t;
endpackage

// ==== verilog/msg_buffer.sv ====
// Two-entry message buffer with valid/ready on both sides
`timescale 1ns/1ps
module msg_buffer
  import stamp_pkg::*;
#(
  parameter int WIDTH = MSG_W,
  parameter int DEPTH = BUF_DEPTH
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Fill side
  input wire logic s_valid_i,
  output logic s_ready_o,
  input wire logic [WIDTH-1:0] s_data_i,
  // Drain side
  output logic m_valid_o,
  input wire logic m_ready_i,
  output logic [WIDTH-1:0] m_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wp_reg;
  logic [PW-1:0] rp_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  assign s_ready_o = cnt_reg != (PW+1)'(DEPTH);
  assign m_valid_o = cnt_reg != '0;
  assign m_data_o = mem_reg[rp_reg];
  assign push = s_valid_i && s_ready_o;
  assign pop = m_valid_o && m_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wp_reg] <= s_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule // msg_buffer

// ==== verification/bus_master_model.sv ====
// Bus master model: answers interrupts, reads and releases reported records
`timescale 1ns/1ps
module bus_master_model
  import stamp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Pace control from the bench
  input wire logic slow_i,
  // From the logger
  input wire logic proc_irq_i,
  input wire logic diag_valid_i,
  input wire logic [7:0] diag_rec_i,
  input wire logic [4:0] diag_cnt_i,
  // To the logger
  output logic diag_req_o,
  output logic rd_req_o,
  output logic rd_release_o,
  output logic [7:0] rd_rec_o,
  output logic [4:0] rd_msg_o
);
  logic [7:0] rec;
  logic [4:0] cnt;

  initial
  begin
    diag_req_o = 1'b0;
    rd_req_o = 1'b0;
    rd_release_o = 1'b0;
    rd_rec_o = 8'h00;
    rd_msg_o = 5'h00;
  end

  // Interrupts arriving while a record is being read are left for the next round
  always
  begin
    @(posedge clk_i);
    if (nrst_i && proc_irq_i)
    begin
      repeat (slow_i ? 20 : 1) @(posedge clk_i);
      diag_req_o <= 1'b1;
      @(posedge clk_i);
      diag_req_o <= 1'b0;
      @(posedge clk_i);
      if (diag_valid_i && diag_rec_i != REC_NONE)
      begin
        rec = diag_rec_i;
        cnt = diag_cnt_i;
        // One read past the count on purpose, so the refusal is seen too
        for (int i = 0; i <= cnt; i++)
        begin
          rd_rec_o <= rec;
          rd_msg_o <= 5'(i);
          rd_req_o <= 1'b1;
          @(posedge clk_i);
          rd_req_o <= 1'b0;
          @(posedge clk_i);
        end
        rd_release_o <= 1'b1;
        @(posedge clk_i);
        rd_release_o <= 1'b0;
        rd_rec_o <= ~rec;
        rd_msg_o <= ~rd_msg_o;
      end
    end
  end
endmodule // bus_master_model

// ==== verification/test_input_event_timestamp_logger.sv ====
// Self-checking bench for the input event time-stamp logger
`timescale 1ns/1ps
module test_input_event_timestamp_logger
  import stamp_pkg::*;
;
  localparam int TICK = 2;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [CH_NUM-1:0] din = 32'h0;
  logic chg = 1'b0;
  logic slow = 1'b0;
  logic cfg_wr = 1'b0;
  logic rise = 1'b0;
  logic rise_ok = 1'b0;
  logic tsync = 1'b0;
  logic [7:0] cfg_rec = 8'h00;
  logic [31:0] mask = 32'h0;
  logic [63:0] tval = 64'h0;
  logic cfg_ack, cfg_err, st_on, synced, irq, dreq, dvalid, rreq, rrel, rvalid, rerr;
  logic [7:0] drec, rrec;
  logic [4:0] dcnt, rmsg;
  logic [MSG_W-1:0] rdata;
  int num_errors = 0;
  int samples_checked = 0;
  int diags = 0;
  int refusals = 0;
  int irqs = 0;
  logic [7:0] qual = 8'h00;
  logic [7:0] exp_rec = REC_FIRST;
  logic [31:0] seed = 32'h56;
  logic [MSG_W-1:0] exp_q[$];
  logic [MSG_W-1:0] msk_q[$];

  always #5 clk_i = ~clk_i;

  input_event_timestamp_logger #(.TICK_CYC(TICK)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .din_i(din), .changeover_i(chg), .active_i(1'b1),
    .mod_present_i(4'h7), .cfg_wr_i(cfg_wr), .cfg_rec_i(cfg_rec), .cfg_chan_mask_i(mask),
    .cfg_rising_in_i(rise), .cfg_ack_o(cfg_ack), .cfg_err_o(cfg_err), .stamping_on_o(st_on),
    .time_sync_i(tsync), .time_val_i(tval), .synced_o(synced), .proc_irq_o(irq),
    .diag_req_i(dreq), .diag_valid_o(dvalid), .diag_rec_o(drec), .diag_cnt_o(dcnt),
    .rd_req_i(rreq), .rd_release_i(rrel), .rd_rec_i(rrec), .rd_msg_i(rmsg),
    .rd_valid_o(rvalid), .rd_err_o(rerr), .rd_data_o(rdata));

  bus_master_model master (
    .clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow), .proc_irq_i(irq), .diag_valid_i(dvalid),
    .diag_rec_i(drec), .diag_cnt_i(dcnt), .diag_req_o(dreq), .rd_req_o(rreq),
    .rd_release_o(rrel), .rd_rec_o(rrec), .rd_msg_o(rmsg));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string n, input logic [MSG_W-1:0] e, input logic [MSG_W-1:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic cfg(input logic [7:0] r, input logic [31:0] m, input logic rs, input logic ok);
    @(posedge clk_i);
    cfg_rec <= r;
    mask <= m;
    rise <= rs;
    cfg_wr <= 1'b1;
    @(posedge clk_i);
    cfg_wr <= 1'b0;
    @(posedge clk_i);
    chk("cfg_ack", ok, cfg_ack);
    chk("cfg_err", !ok, cfg_err);
    if (ok)
      rise_ok = rs;
  endtask

  // Events are spaced so that each lands in a record of its own
  task automatic ev(input int ch, input logic [63:0] t = 64'h0, input logic [MSG_W-1:0] m = 96'hffffffff);
    logic nl;
    nl = ~din[ch];
    exp_q.push_back({t, qual, (nl == rise_ok) ? DIR_IN : DIR_OUT, 8'(ch), MSG_SIGNAL});
    msk_q.push_back(m);
    @(posedge clk_i);
    din[ch] <= nl;
    slow <= ~slow;
    repeat (70) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // Monitor
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (irq)
      irqs++;
    if (rerr)
      refusals++;
    if (dvalid)
    begin
      diags++;
      chk("diag_rec", exp_rec, drec);
      chk("diag_cnt", 5'h1, dcnt);
      exp_rec = (exp_rec == REC_LAST) ? REC_FIRST : exp_rec + 8'h01;
    end
    if (rvalid)
    begin
      if (exp_q.size() == 0)
        chk("rd_extra", 0, 1);
      else
      begin
        chk("rd_data", exp_q[0] & msk_q[0], rdata & msk_q[0]);
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end

  initial
  begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    din[0] <= 1'b1;
    repeat (30) @(posedge clk_i);
    chk("irq_early", 0, irqs);
    chk("stamp_off", 0, st_on);
    cfg(8'h64, 32'h00ffffff, 1'b0, 1'b0);
    cfg(REC_CFG, 32'h01000000, 1'b0, 1'b0);
    cfg(REC_CFG, 32'h0, 1'b0, 1'b0);
    seed = xs(seed);
    cfg(REC_CFG, 32'h00ffffff, seed[0], 1'b1);
    chk("stamp_on", 1, st_on);
    cfg(8'hf1, 32'h000000ff, ~seed[0], 1'b0);
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      ev(int'(seed % 24));
    end
    exp_q.push_back({64'h0, qual, DIR_IN, 8'h00, MSG_CHANGEOVER});
    exp_q.push_back({64'h0, qual, DIR_OUT, 8'h00, MSG_CHANGEOVER});
    msk_q.push_back(96'hffff00ff);
    msk_q.push_back(96'hffff00ff);
    chg <= 1'b1;
    repeat (20) @(posedge clk_i);
    din[5] <= ~din[5];
    repeat (10) @(posedge clk_i);
    din[5] <= ~din[5];
    repeat (20) @(posedge clk_i);
    chg <= 1'b0;
    repeat (100) @(posedge clk_i);
    tsync <= 1'b1;
    @(posedge clk_i);
    tsync <= 1'b0;
    repeat (10000 * TICK - 1) @(posedge clk_i);
    chk("synced_pre", 0, synced);
    tsync <= 1'b1;
    tval <= 64'h2710;
    @(posedge clk_i);
    tsync <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("synced", 1, synced);
    qual = 8'h01;
    // Three ms ticks pass between the frame and the edge capture
    ev(3, tval + 64'h3, '1);
    repeat (50) @(posedge clk_i);
    chk("left", 0, exp_q.size());
    chk("refusals", diags, refusals);
    chk("irqs", diags, irqs);
    // No further frame: the sync window runs out
    repeat (10100 * TICK) @(posedge clk_i);
    chk("synced_lost", 0, synced);
    results();
  end
endmodule // test_input_event_timestamp_logger
